// file: design/gpio_pin_mux.v
// Per-pin function select for the sixteen general-purpose pins
`timescale 1ns/1ps
`include "periph_select_defs.vh"

module gpio_pin_mux (
    input  wire [15:0] gpio_enable_in,
    input  wire [15:0] gpio_direction_in,
    input  wire        pci_select_in,
    output reg  [15:0] gpio_owns_out,
    output reg  [15:0] gpio_out_allowed_out,
    output reg  [15:0] alt_owns_out
);

    integer i;

    // ------------------------------------------------------------------
    // Pin ownership
    // ------------------------------------------------------------------
    // A pin is GPIO only when its enable bit is set; otherwise the
    // alternate function (clock, interrupt, PCI or none) keeps it
    always @* begin
        gpio_owns_out        = 16'h0000;
        gpio_out_allowed_out = 16'h0000;
        alt_owns_out         = 16'h0000;
        for (i = 0; i < 16; i = i + 1) begin
            if (i >= `GPIO_PCI_LO) begin
                if (pci_select_in) begin
                    alt_owns_out[i] = 1'b1;
                end else begin
                    gpio_owns_out[i] = gpio_enable_in[i];
                end
            end else if (i == `GPIO_DIV4_PIN || i == `GPIO_DIV6_PIN || i == `GPIO_CLKSRC_PIN) begin
                gpio_owns_out[i] = gpio_enable_in[i];
                alt_owns_out[i]  = ~gpio_enable_in[i];
            end else if (i >= `GPIO_IRQ_LO && i <= `GPIO_IRQ_HI) begin
                gpio_owns_out[i] = gpio_enable_in[i];
                alt_owns_out[i]  = 1'b1;
            end else begin
                gpio_owns_out[i] = gpio_enable_in[i];
            end
            // Output drive needs both GPIO ownership and direction set
            gpio_out_allowed_out[i] = gpio_owns_out[i] & gpio_direction_in[i];
        end
    end

endmodule

// file: design/periph_select.v
// Reset-latched peripheral selection and shared pin multiplexing
`timescale 1ns/1ps
`include "periph_select_defs.vh"

// Function
// - Sample the straps at the first enabled edge after reset release; use them to assign pins.
// - Cell select 0: serial port one on shared pins, cell pins high impedance.
// - Cell select 1: cell port on shared pins, serial one pins high impedance.
// - PCI select 0: host port owns shared pins; PCI-only pins high impedance.
// - PCI select 0: upper GPIO pins act as GPIO once enable and direction set.
// - PCI select 1: host port off; PCI owns host-shared and GPIO-shared pins.
// - Serial port two off only when PCI select 1 and serial-two select 0.
// - In that combination, EEPROM auto-init runs at reset if strap is 1.
// - Serial-two select may rise after reset; then serial two on, EEPROM off.
// - Timers, serial port zero and lower GPIO pins are always available.
// - Clock-output and clock-source shared pins default to clock function.
// - Interrupt-shared GPIO pins reset as interrupt inputs or input-only GPIO.
// - PCI-shared GPIO pins default to no function until selected.
// - Serial two clock-source pin becomes GPIO 8 only when its enable bit is set.
// - Auto-init strap 1 uses EEPROM only with PCI on and serial-two select 0.
module periph_select (
    input  wire                clk_sys_in,
    input  wire                resetn_in,
    input  wire                clk_en_in,
    input  wire                cell_port_strap_pin_in,
    input  wire                pci_select_pin_in,
    input  wire                serial_port_two_select_in,
    input  wire                eeprom_autoinit_strap_pin_in,
    input  wire [`ADDR_W-1:0]  addr_in,
    input  wire [31:0]         wdata_in,
    input  wire                wr_in,
    input  wire                rd_in,
    output reg  [31:0]         rdata_out,
    output reg                 cell_port_enable_out,
    output reg                 serial1_enable_out,
    output reg                 cell_port_pins_oe_out,
    output reg                 serial1_pins_oe_out,
    output reg                 host_port_enable_out,
    output reg                 pci_enable_out,
    output reg                 pci_only_pins_oe_out,
    output reg                 serial2_enable_out,
    output reg                 eeprom_enable_out,
    output reg                 pci_autoinit_start_out,
    output reg                 serial0_timers_enable_out,
    output reg  [15:0]         gpio_owns_out,
    output reg  [15:0]         gpio_oe_out,
    output reg  [15:0]         alt_owns_out
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    reg        cell_sel_q;
    reg        pci_sel_q;
    reg        eeprom_autoinit_strap_q;
    reg        serial2_sel_q;
    reg        in_reset_q;
    reg        autoinit_done_q;
    reg [15:0] gpio_en_q;
    reg [15:0] gpio_dir_q;
    reg        serial2_on_d;
    wire [15:0] gpio_owns_w;
    wire [15:0] gpio_out_allowed_w;
    wire [15:0] alt_owns_w;

    // Serial port two is off only in the PCI-with-EEPROM combination
    function serial2_on;
        input pci_sel;
        input s2_sel;
        begin
            serial2_on = ~(pci_sel & ~s2_sel);
        end
    endfunction

    // ------------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------------
    // Straps cannot load under the async reset itself, so a reset-marker
    // flop stays set for the first enabled edge and the straps are taken
    // then; straps are expected stable across release
    always @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            in_reset_q              <= 1'b1;
            cell_sel_q              <= 1'b0;
            pci_sel_q               <= 1'b0;
            eeprom_autoinit_strap_q <= 1'b0;
        end else if (clk_en_in && in_reset_q) begin
            in_reset_q              <= 1'b0;
            cell_sel_q              <= cell_port_strap_pin_in;
            pci_sel_q               <= pci_select_pin_in;
            eeprom_autoinit_strap_q <= eeprom_autoinit_strap_pin_in;
        end
        // Later strap changes are ignored until the next reset
    end

    // Serial-two select follows its pin live; it may change any time
    always @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            serial2_sel_q <= 1'b0;
        end else if (clk_en_in) begin
            serial2_sel_q <= serial_port_two_select_in;
        end
    end

    // ------------------------------------------------------------------
    // GPIO configuration registers
    // ------------------------------------------------------------------
    // Enables default clear so every shared pin keeps its alternate use; PCI-shared pins have none unless PCI is selected
    always @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            gpio_en_q  <= `GPIO_EN_RESET;
            gpio_dir_q <= `GPIO_DIR_RESET;
        end else if (clk_en_in && wr_in) begin
            case (addr_in)
                `REG_GPIO_ENABLE: begin
                    gpio_en_q <= wdata_in[15:0];
                end
                `REG_GPIO_DIRECTION: begin
                    gpio_dir_q <= wdata_in[15:0];
                end
                default: begin
                    gpio_en_q <= gpio_en_q;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Register read port, data one cycle after the strobe
    // ------------------------------------------------------------------
    always @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rdata_out <= 32'h0000_0000;
        end else if (clk_en_in) begin
            if (rd_in) begin
                case (addr_in)
                    `REG_GPIO_ENABLE: begin
                        rdata_out <= {16'h0000, gpio_en_q};
                    end
                    `REG_GPIO_DIRECTION: begin
                        rdata_out <= {16'h0000, gpio_dir_q};
                    end
                    `REG_STRAP_STATUS: begin
                        rdata_out <= {28'h000_0000, eeprom_autoinit_strap_q, serial2_sel_q,
                                      pci_sel_q, cell_sel_q};
                    end
                    `REG_OWNER_STATUS: begin
                        rdata_out <= {24'h00_0000, serial0_timers_enable_out, autoinit_done_q,
                                      eeprom_enable_out, serial2_enable_out, pci_enable_out,
                                      host_port_enable_out, serial1_enable_out,
                                      cell_port_enable_out};
                    end
                    default: begin
                        rdata_out <= 32'h0000_0000;
                    end
                endcase
            end else begin
                rdata_out <= 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------------
    // GPIO per-pin mux
    // ------------------------------------------------------------------
    gpio_pin_mux u_gpio_pin_mux (
        .gpio_enable_in       (gpio_en_q),
        .gpio_direction_in    (gpio_dir_q),
        .pci_select_in        (pci_sel_q),
        .gpio_owns_out        (gpio_owns_w),
        .gpio_out_allowed_out (gpio_out_allowed_w),
        .alt_owns_out         (alt_owns_w)
    );

    always @* begin
        serial2_on_d = serial2_on(pci_sel_q, serial2_sel_q);
    end

    // ------------------------------------------------------------------
    // Auto-init launch
    // ------------------------------------------------------------------
    // One pulse after the straps settle; only once per reset, so a later
    // drop of the serial-two select cannot retrigger it
    always @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            autoinit_done_q        <= 1'b0;
            pci_autoinit_start_out <= 1'b0;
        end else if (clk_en_in) begin
            pci_autoinit_start_out <= 1'b0;
            if (!in_reset_q && !autoinit_done_q) begin
                autoinit_done_q <= 1'b1;
                if (pci_sel_q && !serial2_sel_q && eeprom_autoinit_strap_q) begin
                    pci_autoinit_start_out <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Peripheral ownership outputs
    // ------------------------------------------------------------------
    // All outputs registered; peripherals stay off until straps latched
    always @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cell_port_enable_out      <= 1'b0;
            serial1_enable_out        <= 1'b0;
            cell_port_pins_oe_out     <= 1'b0;
            serial1_pins_oe_out       <= 1'b0;
            host_port_enable_out      <= 1'b0;
            pci_enable_out            <= 1'b0;
            pci_only_pins_oe_out      <= 1'b0;
            serial2_enable_out        <= 1'b0;
            eeprom_enable_out         <= 1'b0;
            serial0_timers_enable_out <= 1'b0;
            gpio_owns_out             <= 16'h0000;
            gpio_oe_out               <= 16'h0000;
            alt_owns_out              <= 16'h0000;
        end else if (clk_en_in) begin
            if (in_reset_q) begin
                // Still capturing: keep everything released
                cell_port_enable_out      <= 1'b0;
                serial1_enable_out        <= 1'b0;
                cell_port_pins_oe_out     <= 1'b0;
                serial1_pins_oe_out       <= 1'b0;
                host_port_enable_out      <= 1'b0;
                pci_enable_out            <= 1'b0;
                pci_only_pins_oe_out      <= 1'b0;
                serial2_enable_out        <= 1'b0;
                eeprom_enable_out         <= 1'b0;
                serial0_timers_enable_out <= 1'b0;
                gpio_owns_out             <= 16'h0000;
                gpio_oe_out               <= 16'h0000;
                alt_owns_out              <= 16'h0000;
            end else begin
                cell_port_enable_out      <= cell_sel_q;
                serial1_enable_out        <= ~cell_sel_q;
                cell_port_pins_oe_out     <= cell_sel_q;
                serial1_pins_oe_out       <= ~cell_sel_q;
                host_port_enable_out      <= ~pci_sel_q;
                pci_enable_out            <= pci_sel_q;
                pci_only_pins_oe_out      <= pci_sel_q;
                serial2_enable_out        <= serial2_on_d;
                eeprom_enable_out         <= pci_sel_q & ~serial2_on_d;
                serial0_timers_enable_out <= 1'b1;
                gpio_owns_out             <= gpio_owns_w;
                gpio_oe_out               <= gpio_out_allowed_w;
                alt_owns_out              <= alt_owns_w;
            end
        end
    end

endmodule

// file: design/periph_select_defs.vh
// Constants for the reset-latched peripheral selection block
`ifndef PERIPH_SELECT_DEFS_VH
`define PERIPH_SELECT_DEFS_VH

// ----------------------------------------------------------------------
// Register map (plain port, word index)
// ----------------------------------------------------------------------
`define ADDR_W              4
`define REG_GPIO_ENABLE     4'h0
`define REG_GPIO_DIRECTION  4'h1
`define REG_STRAP_STATUS    4'h2
`define REG_OWNER_STATUS    4'h3

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define GPIO_EN_RESET       16'h0000
`define GPIO_DIR_RESET      16'h0000

// ----------------------------------------------------------------------
// Pin numbers of shared general-purpose pins
// ----------------------------------------------------------------------
`define GPIO_DIV4_PIN       1
`define GPIO_DIV6_PIN       2
`define GPIO_CLKSRC_PIN     8
`define GPIO_IRQ_LO         4
`define GPIO_IRQ_HI         7
`define GPIO_PCI_LO         9

// ----------------------------------------------------------------------
// Owner status bit positions
// ----------------------------------------------------------------------
`define OWN_CELL_PORT       0
`define OWN_SERIAL1         1
`define OWN_HOST_PORT       2
`define OWN_PCI             3
`define OWN_SERIAL2         4
`define OWN_EEPROM          5
`define OWN_AUTOINIT        6
`define OWN_SERIAL0_TIMERS  7

`endif

// file: test/periph_select_asserts.sv
// Port-level checks for the reset-latched peripheral selection block
`timescale 1ns/1ps
module periph_select_asserts (
    input wire        clk_sys_in,
    input wire        resetn_in,
    input wire        clk_en_in,
    input wire        cell_port_strap_pin_in,
    input wire        pci_select_pin_in,
    input wire        serial_port_two_select_in,
    input wire        eeprom_autoinit_strap_pin_in,
    input wire        cell_port_enable_out,
    input wire        serial1_enable_out,
    input wire        cell_port_pins_oe_out,
    input wire        serial1_pins_oe_out,
    input wire        host_port_enable_out,
    input wire        pci_enable_out,
    input wire        pci_only_pins_oe_out,
    input wire        serial2_enable_out,
    input wire        eeprom_enable_out,
    input wire        pci_autoinit_start_out,
    input wire        serial0_timers_enable_out,
    input wire [15:0] gpio_owns_out,
    input wire [15:0] gpio_oe_out,
    input wire [15:0] alt_owns_out
);
    // ------------------------------------------------------------------
    // Own strap latch and enabled-edge count
    // ------------------------------------------------------------------
    reg [2:0] cnt_q;
    reg       cell_q;
    reg       pci_q;
    reg       auto_q;
    reg       s2a_q;
    reg       s2b_q;
    wire      settled = (cnt_q >= 3'h2);

    // Counts only enabled edges, since a low enable freezes the block too
    always @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cnt_q <= 3'h0;
            cell_q <= 1'b0;
            pci_q <= 1'b0;
            auto_q <= 1'b0;
            s2a_q <= 1'b0;
            s2b_q <= 1'b0;
        end else if (clk_en_in) begin
            if (cnt_q != 3'h4) begin
                cnt_q <= cnt_q + 3'h1;
            end
            if (cnt_q == 3'h0) begin
                cell_q <= cell_port_strap_pin_in;
                pci_q <= pci_select_pin_in;
                auto_q <= pci_select_pin_in & ~serial_port_two_select_in & eeprom_autoinit_strap_pin_in;
            end
            s2a_q <= serial_port_two_select_in;
            s2b_q <= s2a_q;
        end
    end

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);

    property p_cell_mux;
        settled |-> cell_port_enable_out == cell_q && serial1_enable_out == !cell_q
            && cell_port_pins_oe_out == cell_q && serial1_pins_oe_out == !cell_q;
    endproperty
    a_cell_mux: assert property (p_cell_mux) else $error("cell port ownership wrong");
    property p_host_pci;
        settled |-> host_port_enable_out == !pci_q && pci_enable_out == pci_q && pci_only_pins_oe_out == pci_q;
    endproperty
    a_host_pci: assert property (p_host_pci) else $error("host or pci ownership wrong");
    property p_serial2;
        settled |-> serial2_enable_out == !(pci_q && !s2b_q);
    endproperty
    a_serial2: assert property (p_serial2) else $error("serial two enable wrong");
    property p_eeprom;
        settled |-> eeprom_enable_out == (pci_q && !s2b_q);
    endproperty
    a_eeprom: assert property (p_eeprom) else $error("eeprom enable wrong");
    property p_autoinit;
        pci_autoinit_start_out == (cnt_q == 3'h2 && auto_q);
    endproperty
    a_autoinit: assert property (p_autoinit) else $error("auto-init pulse wrong");
    property p_always_on;
        settled |-> serial0_timers_enable_out;
    endproperty
    a_always_on: assert property (p_always_on) else $error("timers not enabled");
    property p_pci_gpio;
        settled |-> alt_owns_out[15:9] == {7{pci_q}} && (gpio_owns_out[15:9] & {7{pci_q}}) == 7'h00;
    endproperty
    a_pci_gpio: assert property (p_pci_gpio) else $error("pci shared pins wrong");
    property p_clock_pins;
        settled |-> alt_owns_out[1] != gpio_owns_out[1] && alt_owns_out[2] != gpio_owns_out[2]
            && alt_owns_out[8] != gpio_owns_out[8];
    endproperty
    a_clock_pins: assert property (p_clock_pins) else $error("clock pin owner wrong");
    property p_irq_pins;
        settled |-> alt_owns_out[7:4] == 4'hF;
    endproperty
    a_irq_pins: assert property (p_irq_pins) else $error("interrupt pins not live");
    property p_oe_owned;
        (gpio_oe_out & ~gpio_owns_out) == 16'h0000;
    endproperty
    a_oe_owned: assert property (p_oe_owned) else $error("pin driven while not owned");
endmodule

bind periph_select periph_select_asserts check (
    .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .clk_en_in(clk_en_in),
    .cell_port_strap_pin_in(cell_port_strap_pin_in), .pci_select_pin_in(pci_select_pin_in),
    .serial_port_two_select_in(serial_port_two_select_in),
    .eeprom_autoinit_strap_pin_in(eeprom_autoinit_strap_pin_in),
    .cell_port_enable_out(cell_port_enable_out), .serial1_enable_out(serial1_enable_out),
    .cell_port_pins_oe_out(cell_port_pins_oe_out), .serial1_pins_oe_out(serial1_pins_oe_out),
    .host_port_enable_out(host_port_enable_out), .pci_enable_out(pci_enable_out),
    .pci_only_pins_oe_out(pci_only_pins_oe_out), .serial2_enable_out(serial2_enable_out),
    .eeprom_enable_out(eeprom_enable_out), .pci_autoinit_start_out(pci_autoinit_start_out),
    .serial0_timers_enable_out(serial0_timers_enable_out), .gpio_owns_out(gpio_owns_out),
    .gpio_oe_out(gpio_oe_out), .alt_owns_out(alt_owns_out));

// file: test/reset_latched_peripheral_select_test.sv
// Self-checking bench for the reset-latched peripheral selection block
`timescale 1ns/1ps
`include "periph_select_defs.vh"
module reset_latched_peripheral_select_test;
    reg         clk_sys_in = 1'b0;
    reg         resetn_in = 1'b0;
    reg         clk_en_in = 1'b1;
    reg         wr_in = 1'b0;
    reg         rd_in = 1'b0;
    reg         s2_level = 1'b0;
    reg         disturb = 1'b0;
    reg  [2:0]  fit = 3'h0;
    reg  [3:0]  addr_in = 4'h0;
    reg  [31:0] wdata_in = 32'h0000_0000;
    wire [31:0] rdata_out;
    wire        cell_s, pci_s, s2_s, auto_s;
    wire        cpe, s1e, cpo, s1o, hpe, pce, ppo, s2e, eee, ais, s0e;
    wire [15:0] gpio_owns_out, gpio_oe_out, alt_owns_out;
    wire [9:0]  owners = {cpe, s1e, cpo, s1o, hpe, pce, ppo, s2e, eee, s0e};
    integer     n_fail = 0;
    integer     comparisons = 0;
    integer     cycles = 0;
    integer     i;
    reg         c, p, s, e;

    strap_board board (.resetn_in(resetn_in), .fit_in(fit), .s2_level_in(s2_level), .disturb_in(disturb),
        .cell_out(cell_s), .pci_out(pci_s), .s2_out(s2_s), .autoinit_out(auto_s));
    periph_select dut (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .clk_en_in(clk_en_in),
        .cell_port_strap_pin_in(cell_s), .pci_select_pin_in(pci_s), .serial_port_two_select_in(s2_s),
        .eeprom_autoinit_strap_pin_in(auto_s), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
        .rd_in(rd_in), .rdata_out(rdata_out), .cell_port_enable_out(cpe), .serial1_enable_out(s1e),
        .cell_port_pins_oe_out(cpo), .serial1_pins_oe_out(s1o), .host_port_enable_out(hpe),
        .pci_enable_out(pce), .pci_only_pins_oe_out(ppo), .serial2_enable_out(s2e), .eeprom_enable_out(eee),
        .pci_autoinit_start_out(ais), .serial0_timers_enable_out(s0e), .gpio_owns_out(gpio_owns_out),
        .gpio_oe_out(gpio_oe_out), .alt_owns_out(alt_owns_out));

    // ------------------------------------------------------------------
    // Clock, timeout and shared tasks
    // ------------------------------------------------------------------
    always #10 clk_sys_in = ~clk_sys_in;

    // Whole run needs about 560 cycles; the ceiling leaves ample slack
    always @(posedge clk_sys_in) begin
        cycles = cycles + 1;
        if (cycles == 6000) begin
            n_fail = n_fail + 1;
            close_out;
        end
    end

    task close_out;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task wr(input [3:0] a, input [31:0] d);
        @(posedge clk_sys_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_sys_in);
        wr_in <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task rd(input string nm, input [3:0] a, input [31:0] mask, input [31:0] exp);
        @(posedge clk_sys_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_sys_in);
        rd_in <= 1'b0;
        #1;
        chk(nm, {16'h0000, exp}, {16'h0000, rdata_out & mask});
    endtask

    // Expected {alternate owner, output enable, gpio owner} per pin
    function [47:0] gexp(input [15:0] en, input [15:0] dir, input pci);
        reg [15:0] own;
        reg [15:0] alt;
        begin
            own = en;
            alt = {7'h00, ~en[8], 4'hF, 1'b0, ~en[2], ~en[1], 1'b0};
            if (pci) begin
                own[15:9] = 7'h00;
                alt[15:9] = 7'h7F;
            end
            gexp = {alt, own & dir, own};
        end
    endfunction

    // ------------------------------------------------------------------
    // Every strap combination, then pins, registers and live select
    // ------------------------------------------------------------------
    initial begin
        for (i = 0; i < 16; i = i + 1) begin
            {e, s, p, c} = i[3:0];
            @(posedge clk_sys_in);
            resetn_in <= 1'b0;
            fit <= {e, p, c};
            s2_level <= s;
            disturb <= 1'b0;
            clk_en_in <= 1'b1;
            repeat (3) @(posedge clk_sys_in);
            resetn_in <= 1'b1;
            // Pulse stands between the second and third enabled edges
            repeat (2) @(posedge clk_sys_in);
            #1;
            chk("autoinit", p & ~s & e, ais);
            @(posedge clk_sys_in);
            disturb <= 1'b1;
            repeat (3) @(posedge clk_sys_in);
            #1;
            chk("owners", {c, ~c, c, ~c, ~p, p, p, ~(p & ~s), p & ~s, 1'b1}, owners);
            chk("autoinit once", 1'b0, ais);
            chk("pin defaults", gexp(16'h0000, 16'h0000, p), {alt_owns_out, gpio_oe_out, gpio_owns_out});
            rd("strap status", `REG_STRAP_STATUS, 32'hFFFF_FFFF, {28'h000_0000, e, s, p, c});
            rd("owner status", `REG_OWNER_STATUS, 32'hFFFF_FFFF,
                {24'h00_0000, 2'b11, p & ~s, ~(p & ~s), p, ~p, ~c, c});
            wr(`REG_GPIO_ENABLE, 32'hFFFF_FFFF);
            wr(`REG_GPIO_DIRECTION, 32'h1234_0FF0);
            wr(`REG_OWNER_STATUS, 32'hFFFF_FFFF);
            wr(4'hC, 32'hFFFF_FFFF);
            rd("enable reg", `REG_GPIO_ENABLE, 32'hFFFF_FFFF, 32'h0000_FFFF);
            rd("direction reg", `REG_GPIO_DIRECTION, 32'hFFFF_FFFF, 32'h0000_0FF0);
            rd("unmapped", 4'hC, 32'hFFFF_FFFF, 32'h0000_0000);
            chk("pins set", gexp(16'hFFFF, 16'h0FF0, p), {alt_owns_out, gpio_oe_out, gpio_owns_out});
            // Raise the select while frozen: nothing may move until enabled
            @(posedge clk_sys_in);
            s2_level <= 1'b1;
            clk_en_in <= 1'b0;
            repeat (3) @(posedge clk_sys_in);
            #1;
            chk("frozen serial2", {~(p & ~s), p & ~s}, {s2e, eee});
            @(posedge clk_sys_in);
            clk_en_in <= 1'b1;
            repeat (2) @(posedge clk_sys_in);
            #1;
            chk("serial2 live", 2'b10, {s2e, eee});
        end
        close_out;
    end
endmodule

// file: test/strap_board.sv
// Board strap resistors and the live serial-two select driver
`timescale 1ns/1ps
module strap_board (
    input  wire       resetn_in,
    input  wire [2:0] fit_in,
    input  wire       s2_level_in,
    input  wire       disturb_in,
    output wire       cell_out,
    output wire       pci_out,
    output wire       s2_out,
    output wire       autoinit_out
);
    // ------------------------------------------------------------------
    // Resistors, refitted only while the board holds reset
    // ------------------------------------------------------------------
    reg [2:0] fit_q;

    // Behavioural latch: a board is never rewired while running;
    // a latch process also runs at time zero, so no unknown fit
    always_latch begin
        if (!resetn_in) begin
            fit_q <= fit_in;
        end
    end

    // Disturb flips the free straps after reset to prove they are ignored
    assign cell_out = fit_q[0] ^ disturb_in;
    assign pci_out  = fit_q[1];
    assign autoinit_out = fit_q[2] ^ disturb_in;
    assign s2_out   = s2_level_in;
endmodule
